// ### ctl_host.sv
// Host model of the serial control port, one word per frame.
// Assumes ref_clk paces the bit clock, which idles low.
`timescale 1ns/1ps
module ctl_host
  import dac_ctrl_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Control port
  output ctl_pins_t pins,
  input  wire logic data_out,
  input  wire logic data_oe
);
  initial pins = 3'h5;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Top bit picks direction, read bits taken on the falling bit clock
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    tick(1);
    pins.sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      pins.din = w[i];
      tick(4);
      pins.clk = 1'b1;
      tick(6);
      if (i >= 1 && i <= 8) rd = {rd[6:0], data_oe === 1'b1 ? data_out : 1'bx};
      pins.clk = 1'b0;
    end
    tick(4);
    pins.sel_n = 1'b1;
    pins.din = ~pins.din;
    tick(4);
  endtask
endmodule

// ### dac_control_assertions.sv
// Port checker for the DAC control top.
// Assumes samples change only between frame clock edges.
`timescale 1ns/1ps
module dac_control_assertions
  import dac_ctrl_pkg::*;
#(
  parameter int RUN_FRAMES = ZERO_RUN_FRAMES
) (
  // Clock and reset
  input wire logic                                 ref_clk,
  input wire logic                                 rst,
  // Watched ports
  input wire ctl_pins_t                            ctl_pins,
  input wire logic                                 ctl_data_oe,
  input wire logic                                 frame_clock,
  input wire logic [CHANNELS-1:0][SAMPLE_BITS-1:0] channel_samples,
  input wire sys_clk_ratio_t                       sys_clk_ratio,
  input wire os_ratio_t                            oversample_ratio,
  input wire zero_pins_t                           zero_pins
);
  logic fr_q;
  int   z7_q;
  int   z7_d;
  // Zero frames of channel seven, counted on the raw edge
  always_comb begin
    z7_d = z7_q;
    if (channel_samples[6] != 24'h000000) z7_d = 0;
    else if (frame_clock && !fr_q && z7_q <= RUN_FRAMES) z7_d = z7_q + 1;
  end
  always_ff @(posedge ref_clk) begin
    fr_q <= frame_clock;
    z7_q <= rst ? 0 : z7_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence nz7;
    (channel_samples[6] != 24'h000000) [*2];
  endsequence
  sequence nz8;
    (channel_samples[7] != 24'h000000) [*2];
  endsequence
  pins_reset_a: assert property (disable iff (1'b0) rst |=> zero_pins == 9'h000)
    else $error("zero pins not clear after reset");
  osr_low_a: assert property (!$past(rst) && $stable(sys_clk_ratio) &&
    sys_clk_ratio inside {SCR_128, SCR_192} |-> oversample_ratio != OSR_128X)
    else $error("ratio 128x at low clock ratio");
  osr_high_a: assert property (!$past(rst) && $stable(sys_clk_ratio) &&
    !(sys_clk_ratio inside {SCR_128, SCR_192}) |-> oversample_ratio != OSR_32X)
    else $error("ratio 32x at high clock ratio");
  oe_idle_a: assert property (ctl_pins.sel_n [*5] |-> ctl_data_oe == 1'b0)
    else $error("read drive outside frame");
  clear_seven_a: assert property (nz7 |-> zero_pins.all == zero_pins.seventh)
    else $error("and flag set with channel seven busy");
  clear_eight_a: assert property (nz8 |-> zero_pins.all == zero_pins.eighth)
    else $error("and flag set with channel eight busy");
  early_detect_a: assert property (nz8 ##0 (z7_q < RUN_FRAMES - 1)
    |-> zero_pins.seventh == zero_pins.all)
    else $error("channel seven flagged too early");
  late_detect_a: assert property (nz8 ##0 (z7_q > RUN_FRAMES)
    |-> zero_pins.seventh != zero_pins.all)
    else $error("channel seven not flagged");
endmodule

bind dac_control_top dac_control_assertions #(.RUN_FRAMES(RUN_FRAMES)) dac_control_assertions_inst (
  .ref_clk(ref_clk), .rst(rst), .ctl_pins(ctl_pins), .ctl_data_oe(ctl_data_oe),
  .frame_clock(frame_clock), .channel_samples(channel_samples),
  .sys_clk_ratio(sys_clk_ratio), .oversample_ratio(oversample_ratio), .zero_pins(zero_pins));

// ### dac_control_top.sv
// Control logic of an eight-channel DAC: serial control port, the
// oversampling and general-purpose output register, zero-flag polarity,
// per-channel zero detection and the multipurpose pin mux.
// Assumes control pins and frame clock are asynchronous to ref_clk and
// channel samples come from same-clock logic, stable at frame edges.
`timescale 1ns/1ps

// How it works
// - Word top bit: 0 writes, 1 reads
// - Oversample bit and clock ratio pick ratio
// - Output enable clear: pins show zero flags
// - Output enable set: pins show output bits
// - Output bits read/write, reset zero, drive level
// - Zero after 1024 all-zero frames
// - Each channel has own counter and flag
// - Flag pins active for detecting channels
// - All-channel flag is AND of eight
// - Polarity bit inverts every zero flag
module dac_control_top
  import dac_ctrl_pkg::*;
#(
  parameter int RUN_FRAMES = ZERO_RUN_FRAMES
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  // Serial control port
  input  wire ctl_pins_t                             ctl_pins,
  output logic                                       ctl_data_out,
  output logic                                       ctl_data_oe,
  // Audio frame timing and samples
  input  wire logic                                  frame_clock,
  input  wire logic [CHANNELS-1:0][SAMPLE_BITS-1:0]  channel_samples,
  // Clock ratio and oversampling
  input  wire sys_clk_ratio_t                        sys_clk_ratio,
  output os_ratio_t                                  oversample_ratio,
  // Zero flag and general-purpose pins
  output zero_pins_t                                 zero_pins
);

  if (RUN_FRAMES < 2 || RUN_FRAMES > 65536) begin : g_bad_run
    $error("RUN_FRAMES out of range");
  end

  typedef enum logic [1:0] {
    PS_IDLE, PS_ADDR, PS_DATA, PS_WAIT_END
  } port_state_t;

  // Read value of a register index
  function automatic logic [DATA_BITS-1:0] read_mux(
    input logic [IDX_BITS-1:0]  idx,
    input logic                 over,
    input logic                 gp_en,
    input logic [GPO_COUNT-1:0] gpo,
    input logic                 zpol
  );
    logic [DATA_BITS-1:0] v;
    v = '0;
    if (idx == REG_IDX_OVER_GPO) begin
      v[OVER_BIT]         = over;
      v[GP_EN_BIT]        = gp_en;
      v[GPO_MSB:0]        = gpo;
    end else if (idx == REG_IDX_ZERO_POL) begin
      v[ZPOL_BIT]         = zpol;
    end
    return v;
  endfunction

  // Oversampling ratio from clock ratio and select bit
  function automatic os_ratio_t os_decode(
    input sys_clk_ratio_t ratio,
    input logic           over
  );
    os_ratio_t r;
    if (ratio == SCR_128 || ratio == SCR_192) begin
      r = over ? OSR_64X : OSR_32X;
    end else begin
      r = over ? OSR_128X : OSR_64X;
    end
    return r;
  endfunction

  // Synchronised pins
  logic [3:0] pins_s;
  logic       sel_n_s;
  logic       sclk_s;
  logic       din_s;
  logic       frame_s;

  sync2 #(
    .WIDTH (4)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({ctl_pins.sel_n, ctl_pins.clk, ctl_pins.din, frame_clock}),
    .sync_out (pins_s)
  );

  assign sel_n_s = pins_s[3];
  assign sclk_s  = pins_s[2];
  assign din_s   = pins_s[1];
  assign frame_s = pins_s[0];

  // Serial port state
  port_state_t               state_q, state_d;
  logic [4:0]                bits_q, bits_d;
  logic [CTL_WORD_BITS-1:0]  shift_q, shift_d;
  logic [DATA_BITS-1:0]      rd_q, rd_d;
  logic                      dout_q, dout_d;
  logic                      oe_q, oe_d;
  logic                      sclk_prev_q, sclk_prev_d;
  logic                      wr_en;
  logic                      sclk_rise;

  // Register state
  logic                      over_q, over_d;
  logic                      gp_en_q, gp_en_d;
  logic [GPO_COUNT-1:0]      gpo_q, gpo_d;
  logic                      zpol_q, zpol_d;

  // Output state
  os_ratio_t                 osr_q, osr_d;
  zero_pins_t                zp_q, zp_d;
  logic                      frame_prev_q, frame_prev_d;

  assign sclk_rise = sclk_s && !sclk_prev_q;

  always_comb begin
    state_d     = state_q;
    bits_d      = bits_q;
    shift_d     = shift_q;
    rd_d        = rd_q;
    dout_d      = dout_q;
    oe_d        = oe_q;
    sclk_prev_d = sclk_s;
    wr_en       = 1'b0;
    if (sel_n_s) begin
      // Frame end: commit a complete write word
      if (state_q == PS_WAIT_END && !shift_q[CW_RW_BIT]) begin
        wr_en = 1'b1;
      end
      state_d = PS_IDLE;
      bits_d  = '0;
      oe_d    = 1'b0;
      dout_d  = 1'b0;
    end else begin
      case (state_q)
        PS_IDLE: begin
          state_d = PS_ADDR;
          bits_d  = '0;
        end
        PS_ADDR: begin
          if (sclk_rise) begin
            shift_d = {shift_q[CTL_WORD_BITS-2:0], din_s};
            bits_d  = bits_q + 5'h01;
            if (bits_q + 5'h01 == ADDR_PHASE_BITS) begin
              state_d = PS_DATA;
              if (shift_d[DATA_BITS-1]) begin
                // Read: drive register bits out during data phase
                rd_d   = read_mux(shift_d[IDX_BITS-1:0], over_q, gp_en_q,
                                  gpo_q, zpol_q);
                oe_d   = 1'b1;
                dout_d = rd_d[DATA_BITS-1];
              end
            end
          end
        end
        PS_DATA: begin
          if (sclk_rise) begin
            shift_d = {shift_q[CTL_WORD_BITS-2:0], din_s};
            bits_d  = bits_q + 5'h01;
            rd_d    = {rd_q[DATA_BITS-2:0], 1'b0};
            dout_d  = rd_d[DATA_BITS-1];
            if (bits_q + 5'h01 == WORD_DONE_BITS) begin
              state_d = PS_WAIT_END;
              oe_d    = 1'b0;
              dout_d  = 1'b0;
            end
          end
        end
        PS_WAIT_END: begin
          state_d = PS_WAIT_END;
        end
        default: begin
          state_d = PS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= PS_IDLE;
      bits_q      <= '0;
      shift_q     <= '0;
      rd_q        <= '0;
      dout_q      <= 1'b0;
      oe_q        <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      bits_q      <= bits_d;
      shift_q     <= shift_d;
      rd_q        <= rd_d;
      dout_q      <= dout_d;
      oe_q        <= oe_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  assign ctl_data_out = dout_q;
  assign ctl_data_oe  = oe_q;

  // Register writes
  always_comb begin
    over_d = over_q;
    gp_en_d = gp_en_q;
    gpo_d  = gpo_q;
    zpol_d = zpol_q;
    if (wr_en) begin
      if (shift_q[CW_IDX_MSB:CW_IDX_LSB] == REG_IDX_OVER_GPO) begin
        over_d = shift_q[OVER_BIT];
        gp_en_d = shift_q[GP_EN_BIT];
        gpo_d  = shift_q[GPO_MSB:0];
      end else if (shift_q[CW_IDX_MSB:CW_IDX_LSB] == REG_IDX_ZERO_POL) begin
        zpol_d = shift_q[ZPOL_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      over_q <= OVER_RESET;
      gp_en_q <= GP_EN_RESET;
      gpo_q  <= GPO_RESET;
      zpol_q <= ZPOL_RESET;
    end else begin
      over_q <= over_d;
      gp_en_q <= gp_en_d;
      gpo_q  <= gpo_d;
      zpol_q <= zpol_d;
    end
  end

  // Zero detection, one counter per channel
  logic                frame_tick;
  logic [CHANNELS-1:0] zero_det;

  assign frame_tick = frame_s && !frame_prev_q;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_zero
    zero_run_counter #(
      .RUN_FRAMES (RUN_FRAMES)
    ) u_zrc (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .frame_tick  (frame_tick),
      .sample_zero (channel_samples[ch] == '0),
      .detect      (zero_det[ch])
    );
  end

  // Pin drive and oversampling output
  always_comb begin
    frame_prev_d = frame_s;
    osr_d        = os_decode(sys_clk_ratio, over_q);
    if (gp_en_q) begin
      zp_d.multipurpose = gpo_q;
    end else begin
      zp_d.multipurpose = zero_det[GPO_COUNT-1:0] ^ {GPO_COUNT{zpol_q}};
    end
    zp_d.seventh = zero_det[CHANNELS-2] ^ zpol_q;
    zp_d.eighth  = zero_det[CHANNELS-1] ^ zpol_q;
    zp_d.all     = (&zero_det) ^ zpol_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_prev_q <= 1'b0;
      osr_q        <= OSR_64X;
      zp_q         <= '0;
    end else begin
      frame_prev_q <= frame_prev_d;
      osr_q        <= osr_d;
      zp_q         <= zp_d;
    end
  end

  assign oversample_ratio = osr_q;
  assign zero_pins        = zp_q;

endmodule

// ### dac_control_top_tb_top.sv
// Bench for the DAC control top with host model and sample model.
// Assumes the zero run is shortened to four frames.
`timescale 1ns/1ps
module dac_control_top_tb_top;
  import dac_ctrl_pkg::*;
  localparam int RUN = 4;
  logic                                 ref_clk, rst, frame_clock, ctl_data_out, ctl_data_oe;
  logic [CHANNELS-1:0][SAMPLE_BITS-1:0] smp;
  ctl_pins_t                            pins;
  sys_clk_ratio_t                       ratio;
  os_ratio_t                            osr;
  zero_pins_t                           zp;
  logic [31:0]                          seed;
  logic [7:0]                           rd, d;
  logic                                 pol;
  int                                   fails, total_checks, cnt[CHANNELS];
  dac_control_top #(.RUN_FRAMES(RUN)) dac_control_top_inst (
    .ref_clk(ref_clk), .rst(rst), .ctl_pins(pins), .ctl_data_out(ctl_data_out),
    .ctl_data_oe(ctl_data_oe), .frame_clock(frame_clock), .channel_samples(smp),
    .sys_clk_ratio(ratio), .oversample_ratio(osr), .zero_pins(zp));
  ctl_host ctl_host_inst (
    .ref_clk(ref_clk), .pins(pins), .data_out(ctl_data_out), .data_oe(ctl_data_oe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic frames(input int n, input logic [7:0] fix_nz, input logic [7:0] rnd_nz);
    logic [7:0] m;
    logic [7:0] f;
    for (int k = 0; k < n; k++) begin
      seed = xs(seed);
      m = fix_nz | (rnd_nz & seed[7:0] & seed[15:8]);
      for (int c = 0; c < CHANNELS; c++)
        smp[c] = m[c] ? ((seed[31:8] ^ 24'(c)) | 24'h000001) : 24'h000000;
      tick(10);
      frame_clock = 1'b1;
      for (int c = 0; c < CHANNELS; c++)
        cnt[c] = m[c] ? 0 : (cnt[c] < RUN ? cnt[c] + 1 : RUN);
      tick(10);
      for (int c = 0; c < CHANNELS; c++) f[c] = cnt[c] >= RUN && !m[c];
      chk("zero_pins", {d[6] ? d[5:0] : f[5:0] ^ {6{pol}}, f[6] ^ pol, f[7] ^ pol,
        (&f) ^ pol}, zp);
      frame_clock = 1'b0;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    fails++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    frame_clock = 1'b0;
    smp = '0;
    ratio = SCR_256;
    seed = 32'h00000030;
    d = 8'h00;
    pol = 1'b0;
    fails = 0;
    total_checks = 0;
    foreach (cnt[c]) cnt[c] = 0;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    tick(2);
    ctl_host_inst.xfer(16'h8c00, rd);
    chk("reg12", 16'h0000, rd);
    ctl_host_inst.xfer(16'h8a00, rd);
    chk("reg10", 16'h0000, rd);
    ctl_host_inst.xfer(16'h9300, rd);
    chk("unmapped", 16'h0000, rd);
    frames(RUN + 3, 8'h80, 8'h00);
    frames(RUN + 2, 8'h00, 8'h00);
    frames(40, 8'h00, 8'hff);
    ctl_host_inst.xfer(16'h0a40, rd);
    pol = 1'b1;
    ctl_host_inst.xfer(16'h8a00, rd);
    chk("reg10", 16'h0040, rd);
    frames(RUN + 2, 8'h00, 8'h00);
    frames(20, 8'h00, 8'hff);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      d = seed[7:0];
      d[6] = k[0];
      ctl_host_inst.xfer({8'h0c, d}, rd);
      ctl_host_inst.xfer(16'h8c00, rd);
      chk("reg12", d, rd);
      frames(RUN + 1, 8'h00, 8'hff);
      for (int s = 0; s < 6; s++) begin
        ratio = sys_clk_ratio_t'(s);
        tick(2);
        chk("osr", d[7] ? (s < 2 ? OSR_64X : OSR_128X) : (s < 2 ? OSR_32X : OSR_64X), osr);
      end
    end
    ratio = SCR_128;
    ctl_host_inst.xfer(16'h0c80, rd);
    tick(2);
    chk("osr", OSR_64X, osr);
    stop_test;
  end
endmodule

// ### dac_ctrl_pkg.sv
// Constants and types shared by the DAC control block.
// Assumes a single 25 MHz reference clock domain.
package dac_ctrl_pkg;

  // Control word layout
  localparam int CTL_WORD_BITS = 16;
  localparam int CW_RW_BIT     = 15;
  localparam int CW_IDX_MSB    = 14;
  localparam int CW_IDX_LSB    = 8;
  localparam int IDX_BITS      = 7;
  localparam int DATA_BITS     = 8;
  localparam logic [4:0] ADDR_PHASE_BITS = 5'h08;
  localparam logic [4:0] WORD_DONE_BITS  = 5'h10;

  // Register indices
  localparam logic [IDX_BITS-1:0] REG_IDX_ZERO_POL = 7'h0a;
  localparam logic [IDX_BITS-1:0] REG_IDX_OVER_GPO = 7'h0c;

  // Field positions
  localparam int OVER_BIT  = 7;
  localparam int GP_EN_BIT = 6;
  localparam int GPO_MSB   = 5;
  localparam int ZPOL_BIT  = 6;
  localparam int GPO_COUNT = 6;

  // Reset values
  localparam logic                 OVER_RESET  = 1'b0;
  localparam logic                 GP_EN_RESET = 1'b0;
  localparam logic [GPO_COUNT-1:0] GPO_RESET   = 6'h00;
  localparam logic                 ZPOL_RESET  = 1'b0;

  // Zero detection
  localparam int CHANNELS        = 8;
  localparam int SAMPLE_BITS     = 24;
  localparam int ZERO_RUN_FRAMES = 1024;

  typedef enum logic [2:0] {
    SCR_128, SCR_192, SCR_256, SCR_384, SCR_512, SCR_768
  } sys_clk_ratio_t;

  typedef enum logic [1:0] {
    OSR_32X, OSR_64X, OSR_128X
  } os_ratio_t;

  typedef struct packed {
    logic sel_n;
    logic clk;
    logic din;
  } ctl_pins_t;

  typedef struct packed {
    logic [GPO_COUNT-1:0] multipurpose;
    logic                 seventh;
    logic                 eighth;
    logic                 all;
  } zero_pins_t;

endpackage

// ### sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the levels are slow against ref_clk.
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### zero_run_counter.sv
// Zero-run counter for one audio channel.
// Assumes frame_tick pulses once per frame and sample_zero is valid then.
`timescale 1ns/1ps
module zero_run_counter #(
  parameter int RUN_FRAMES = 1024
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Sample status
  input  wire logic frame_tick,
  input  wire logic sample_zero,
  // Result
  output logic      detect
);

  localparam int CW = $clog2(RUN_FRAMES + 1);
  localparam logic [CW-1:0] RUN_LIMIT = CW'(RUN_FRAMES);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (frame_tick) begin
      if (!sample_zero) begin
        count_d = '0;
      end else if (count_q != RUN_LIMIT) begin
        count_d = count_q + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Nonzero data drops the condition at once
  assign detect = (count_q == RUN_LIMIT) && sample_zero;

endmodule
